// [core/lcdi_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lcdi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import lcdi_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  // Pointers wrap naturally, so depth must be a power of two
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("lcdi_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lcdi_fifo_s;

  lcdi_fifo_s q;
  lcdi_fifo_s next_q;
  logic do_push;
  logic do_pop;

  // Flags come from the stored count
  assign in_ready_out = (q.cnt != FULL);
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = q.mem[q.rd];

  // Next state of storage and pointers
  always_comb begin
    next_q = q;
    do_push = in_valid_in && in_ready_out;
    do_pop = out_valid_out && out_ready_in;
    if (do_push) begin
      next_q.mem[q.wr] = in_data_in;
      next_q.wr = q.wr + 1'b1;
    end
    if (do_pop) begin
      next_q.rd = q.rd + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_q.cnt = q.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      next_q.cnt = q.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// [core/lcdi_i2c_slave.sv]
// I2C slave port of the character LCD driver with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module lcdi_i2c_slave #(
  parameter int PTR_W = lcdi_pkg::PTR_W_DEF,
  parameter int FIFO_DEPTH = lcdi_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // I2C pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic address_select_strap_in,
  // Command byte path
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  input wire logic cmd_ready_in,
  // Display memory byte path
  output logic ram_valid_out,
  output logic [PTR_W-1:0] ram_addr_out,
  output logic [7:0] ram_byte_out,
  input wire logic ram_ready_in,
  // AXI4-Lite write channels
  input wire logic [lcdi_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [lcdi_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import lcdi_pkg::*;
  localparam int FW = 1 + PTR_W + 8;

  // Pointer must fit the low byte of its register
  generate
    if (PTR_W < 1 || PTR_W > 8) begin : g_bad_ptr
      $error("lcdi_i2c_slave pointer width must be 1 to 8");
    end
  endgenerate

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] strap_s;
    lcdi_state_e st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic expect_ctl;
    logic ctl_more;
    logic ram_sel;
    logic master_ack;
    logic [PTR_W-1:0] ptr;
    logic sda_oe;
    logic scl_oe;
    logic enable;
    logic [7:0] tx_data;
    logic [7:0] rx_count;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lcdi_state_s;

  lcdi_state_s q;
  lcdi_state_s next_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_now;
  logic addr_hit;
  logic push;
  logic [FW-1:0] push_data;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop_ready;
  logic [FW-1:0] fifo_data;

  // Register index of a bus address, shared by read and write decode
  function automatic logic [2:0] reg_index(input logic [AXI_ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = 3'h4;
    if (a == OFS_CTRL) begin
      idx = 3'h0;
    end else if (a == OFS_PTR) begin
      idx = 3'h1;
    end else if (a == OFS_TXDATA) begin
      idx = 3'h2;
    end else if (a == OFS_STATUS) begin
      idx = 3'h3;
    end
    return idx;
  endfunction

  // Line events seen on the second and third synchroniser stages
  assign sda_now = q.sda_s[1];
  assign scl_rise = q.scl_s[1] && !q.scl_s[2];
  assign scl_fall = !q.scl_s[1] && q.scl_s[2];
  assign bus_start = q.scl_s[1] && q.scl_s[2] && !q.sda_s[1] && q.sda_s[2];
  assign bus_stop = q.scl_s[1] && q.scl_s[2] && q.sda_s[1] && !q.sda_s[2];
  // Fixed part and strap level must both match the address byte
  assign addr_hit = q.enable && (q.sh[7:2] == ADDR_FIXED)
    && (q.sh[1] == q.strap_s[1]);

  // Pins only ever pull low; the line level is from the enables
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = q.scl_oe;
  assign sda_oe_out = q.sda_oe;

  // Byte buffer toward the command and memory paths
  lcdi_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop_ready),
    .out_data_out(fifo_data)
  );

  // Steer the buffer head to the path its target flag names
  assign fifo_pop_ready = fifo_data[FW-1] ? ram_ready_in : cmd_ready_in;
  assign cmd_valid_out = fifo_valid && !fifo_data[FW-1];
  assign ram_valid_out = fifo_valid && fifo_data[FW-1];
  assign cmd_byte_out = fifo_data[7:0];
  assign ram_byte_out = fifo_data[7:0];
  assign ram_addr_out = fifo_data[FW-2:8];

  // Serial engine and register file next state
  always_comb begin
    next_q = q;
    push = 1'b0;
    push_data = '0;
    next_q.scl_s = {q.scl_s[1:0], scl_in};
    next_q.sda_s = {q.sda_s[1:0], sda_in};
    next_q.strap_s = {q.strap_s[0], address_select_strap_in};
    case (q.st)
      ST_IDLE: begin
        // Only a START leaves idle; nothing here drives the bus
        next_q.sda_oe = 1'b0;
      end
      ST_ADDR, ST_RX: begin
        if (scl_rise) begin
          next_q.sh = {q.sh[6:0], sda_now};
          next_q.bits = q.bits + 4'h1;
        end else if (scl_fall && q.bits == BYTE_BITS) begin
          next_q.bits = '0;
          if (q.st == ST_ADDR) begin
            if (addr_hit) begin
              next_q.sda_oe = 1'b1;
              next_q.st = ST_ACK;
              next_q.rw = q.sh[0];
              next_q.expect_ctl = !q.sh[0];
              next_q.ctl_more = 1'b0;
            end else begin
              next_q.st = ST_IGNORE;
            end
          end else begin
            // Park the byte; the hold state decides on stretching
            next_q.st = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (q.expect_ctl) begin
          next_q.ctl_more = q.sh[CTL_MORE_BIT];
          next_q.ram_sel = (q.sh[CTL_TGT_HI:CTL_TGT_LO] == TGT_RAM);
          next_q.expect_ctl = 1'b0;
          next_q.rx_count = q.rx_count + 8'h01;
          next_q.sda_oe = 1'b1;
          next_q.st = ST_ACK;
        end else if (fifo_ready) begin
          push = 1'b1;
          push_data = {q.ram_sel, q.ptr, q.sh};
          if (q.ram_sel) begin
            next_q.ptr = q.ptr + 1'b1;
          end
          // A set continuation flag makes the next byte control again
          next_q.expect_ctl = q.ctl_more;
          next_q.rx_count = q.rx_count + 8'h01;
          next_q.sda_oe = 1'b1;
          next_q.st = ST_ACK;
        end else begin
          // Full buffer: stretch SCL until a slot frees
          next_q.scl_oe = 1'b1;
        end
      end
      ST_ACK: begin
        // Low is held across the whole high phase of the ack clock
        next_q.scl_oe = 1'b0; // SCL freed a cycle after SDA is pulled
        if (scl_fall) begin
          next_q.bits = '0;
          if (q.rw) begin
            next_q.sh = q.tx_data;
            next_q.sda_oe = !q.tx_data[7];
            next_q.bits = 4'h1;
            next_q.st = ST_TX;
          end else begin
            next_q.sda_oe = 1'b0;
            next_q.st = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (q.bits == BYTE_BITS) begin
            next_q.sda_oe = 1'b0;
            next_q.bits = '0;
            next_q.st = ST_TXACK;
          end else begin
            next_q.sh = {q.sh[6:0], 1'b0};
            next_q.sda_oe = !q.sh[6];
            next_q.bits = q.bits + 4'h1;
          end
        end
      end
      ST_TXACK: begin
        if (scl_rise) begin
          next_q.master_ack = !sda_now;
        end else if (scl_fall) begin
          if (q.master_ack) begin
            next_q.sh = q.tx_data;
            next_q.sda_oe = !q.tx_data[7];
            next_q.bits = 4'h1;
            next_q.st = ST_TX;
          end else begin
            next_q.sda_oe = 1'b0;
            next_q.st = ST_IGNORE;
          end
        end
      end
      ST_IGNORE: begin
        next_q.sda_oe = 1'b0;
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
    // Line conditions override any byte in progress
    if (bus_start) begin
      next_q.st = ST_ADDR;
      next_q.bits = '0;
      next_q.sda_oe = 1'b0;
      next_q.scl_oe = 1'b0;
    end else if (bus_stop) begin
      next_q.st = ST_IDLE;
      next_q.bits = '0;
      next_q.sda_oe = 1'b0;
      next_q.scl_oe = 1'b0;
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid_in && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.waddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata_in;
      next_q.wstrb = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      next_q.bvalid = 1'b0;
    end
    // Perform the write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      case (reg_index(q.waddr))
        3'h0: begin
          if (q.wstrb[0]) begin
            next_q.enable = q.wdata[CTRL_ENABLE_BIT];
          end
        end
        3'h1: begin
          if (q.wstrb[0]) begin
            next_q.ptr = q.wdata[PTR_W-1:0];
          end
        end
        3'h2: begin
          if (q.wstrb[0]) begin
            next_q.tx_data = q.wdata[7:0];
          end
        end
        3'h3: begin
          next_q.bresp = RESP_OKAY;
        end
        default: begin
          next_q.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Read answer is loaded on the address handshake
    if (q.rvalid && s_axi_rready_in) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = '0;
      next_q.rresp = RESP_OKAY;
      case (reg_index(s_axi_araddr_in))
        3'h0: next_q.rdata[CTRL_ENABLE_BIT] = q.enable;
        3'h1: next_q.rdata[PTR_W-1:0] = q.ptr;
        3'h2: next_q.rdata[7:0] = q.tx_data;
        3'h3: begin
          next_q.rdata[STAT_BUSY_BIT] = (q.st != ST_IDLE) && (q.st != ST_IGNORE);
          next_q.rdata[STAT_RW_BIT] = q.rw;
          next_q.rdata[STAT_RAM_BIT] = q.ram_sel;
          next_q.rdata[STAT_MORE_BIT] = q.ctl_more;
          next_q.rdata[STAT_CNT_LSB+7:STAT_CNT_LSB] = q.rx_count;
        end
        default: next_q.rresp = RESP_SLVERR;
      endcase
    end
    // Ready flags registered from the next occupancy
    next_q.awready = !next_q.aw_got && !next_q.bvalid;
    next_q.wready = !next_q.w_got && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;
  end

  // State register; lines reset to their released high level
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.st <= ST_IDLE;
      q.enable <= RST_ENABLE;
      q.tx_data <= RST_TXDATA;
      q.bresp <= RESP_OKAY;
      q.rresp <= RESP_OKAY;
    end else begin
      q <= next_q;
    end
  end

  // Bus outputs straight from the state register
  assign s_axi_awready_out = q.awready;
  assign s_axi_wready_out = q.wready;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = q.arready;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;
endmodule

// [core/lcdi_pkg.sv]
// Constants, types and register map of the LCD driver I2C slave port
package lcdi_pkg;
  // Bus address slot
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PTR = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // Reset values
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [7:0] RST_TXDATA = 8'h00;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RW_BIT = 1;
  localparam int STAT_RAM_BIT = 2;
  localparam int STAT_MORE_BIT = 3;
  localparam int STAT_CNT_LSB = 8;
  // Device address byte
  localparam logic [5:0] ADDR_FIXED = 6'h1D;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Control byte fields
  localparam int CTL_MORE_BIT = 7;
  localparam int CTL_TGT_HI = 6;
  localparam int CTL_TGT_LO = 5;
  localparam logic [1:0] TGT_RAM = 2'h1;
  // Default sizes
  localparam int PTR_W_DEF = 7;
  localparam int FIFO_DEPTH_DEF = 4;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_RX = 3'h2,
    ST_HOLD = 3'h3,
    ST_ACK = 3'h4,
    ST_TX = 3'h5,
    ST_TXACK = 3'h6,
    ST_IGNORE = 3'h7
  } lcdi_state_e;
endpackage

// [verification/lcdi_i2c_master_model.sv]
// Behavioural I2C bus master that only pulls the lines low
`timescale 1ns/1ps
module lcdi_i2c_master_model #(
  parameter int QTR = 8
) (
  // Clock and bus lines
  input wire logic sys_clk_in,
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  // Pull-down enables
  output logic scl_oe_out = 1'b0,
  output logic sda_oe_out = 1'b0
);
  // Wait a number of clocks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Release SCL and wait out any stretch by the slave
  task automatic scl_up;
    tick(QTR);
    scl_oe_out <= 1'b0;
    do @(posedge sys_clk_in); while (scl_line_in !== 1'b1);
    tick(QTR);
  endtask
  // One bit: SDA moves only while SCL is low, sampled while high
  task automatic bit_out(input logic b, output logic seen);
    sda_oe_out <= ~b;
    scl_up();
    seen = sda_line_in;
    scl_oe_out <= 1'b1;
    tick(QTR);
  endtask
  // START or repeated START: SDA falls while SCL is high
  task automatic start;
    sda_oe_out <= 1'b0;
    scl_up();
    sda_oe_out <= 1'b1;
    tick(QTR);
    scl_oe_out <= 1'b1;
    tick(QTR);
  endtask
  // STOP: SDA rises while SCL is high
  task automatic stop;
    sda_oe_out <= 1'b1;
    scl_up();
    sda_oe_out <= 1'b0;
    tick(QTR);
  endtask
  // Byte out MSB first, then SDA released for the ack slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(d[i], s);
    bit_out(1'b1, s);
    ack = ~s;
  endtask
  // Byte in; ack it when ack is set, withhold the ack otherwise
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(1'b1, s);
      d[i] = s;
    end
    bit_out(~ack, s);
  endtask
endmodule

// [verification/lcdi_i2c_slave_assertions.sv]
// Checker of the I2C slave port pins and byte streams
`timescale 1ns/1ps
module lcdi_i2c_slave_checker #(
  parameter int PTR_W = 7
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Byte streams
  input wire logic cmd_valid_out,
  input wire logic [7:0] cmd_byte_out,
  input wire logic cmd_ready_in,
  input wire logic ram_valid_out,
  input wire logic [PTR_W-1:0] ram_addr_out,
  input wire logic [7:0] ram_byte_out,
  input wire logic ram_ready_in
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Pin relations
  property p_low; !scl_out && !sda_out; endproperty
  a_low: assert property (p_low) else $error("pin driven high");
  property p_ack_rise; $rose(sda_oe_out) |-> !scl_in; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("sda pulled in scl high");
  property p_ack_fall; $fell(sda_oe_out) |-> !scl_in; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("sda freed in scl high");
  property p_ack_high; $rose(scl_in) && sda_oe_out |-> sda_oe_out [*3]; endproperty
  a_ack_high: assert property (p_ack_high) else $error("sda low not held");
  property p_str_low; $rose(scl_oe_out) |-> !scl_in; endproperty
  a_str_low: assert property (p_str_low) else $error("stretch in scl high");
  property p_str_full; scl_oe_out |-> cmd_valid_out || ram_valid_out; endproperty
  a_str_full: assert property (p_str_full) else $error("stretch with empty buffer");
  // Stream holds
  property p_cmd_hold;
    cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_byte_out);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command byte dropped");
  property p_ram_hold;
    ram_valid_out && !ram_ready_in |=> ram_valid_out && $stable({ram_addr_out, ram_byte_out});
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("display byte dropped");
  // Main scenarios
  c_ack: cover property ($rose(sda_oe_out));
  c_str: cover property ($rose(scl_oe_out));
  c_ram: cover property (ram_valid_out && ram_ready_in);
endmodule

bind lcdi_i2c_slave lcdi_i2c_slave_checker #(.PTR_W(PTR_W)) chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .cmd_valid_out(cmd_valid_out), .cmd_byte_out(cmd_byte_out), .cmd_ready_in(cmd_ready_in),
  .ram_valid_out(ram_valid_out), .ram_addr_out(ram_addr_out),
  .ram_byte_out(ram_byte_out), .ram_ready_in(ram_ready_in)
);

// [verification/lcdi_i2c_slave_bench.sv]
// Self-checking bench of the LCD driver I2C slave port
`timescale 1ns/1ps
module lcdi_i2c_slave_bench;
  import lcdi_pkg::*;
  localparam int PW = 7;
  logic clk = 1'b0, rst = 1'b1, strap = 1'b1, stall = 1'b0, str_seen = 1'b0;
  logic cmd_ready = 1'b0, ram_ready = 1'b0, m_scl_oe, m_sda_oe, scl_oe, sda_oe;
  logic scl_line, sda_line, cmd_valid, ram_valid, ack;
  logic [7:0] cmd_byte, ram_byte, d, awaddr = 8'h00, araddr = 8'h00;
  logic [PW-1:0] ram_addr, ptr;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] exp_cmd[$];
  logic [PW+7:0] exp_ram[$];
  int err_count = 0, check_count = 0, seed = 72, rnd;

  // Clock and pulled-up open-drain lines
  always #10 clk = ~clk;
  assign scl_line = ~(m_scl_oe | scl_oe);
  assign sda_line = ~(m_sda_oe | sda_oe);

  lcdi_i2c_slave #(.PTR_W(PW), .FIFO_DEPTH(4)) dut (
    .sys_clk_in(clk), .sys_rst_in(rst), .scl_in(scl_line), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe), .address_select_strap_in(strap),
    .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .cmd_ready_in(cmd_ready),
    .ram_valid_out(ram_valid), .ram_addr_out(ram_addr), .ram_byte_out(ram_byte),
    .ram_ready_in(ram_ready), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready)
  );

  lcdi_i2c_master_model #(.QTR(8)) mst (
    .sys_clk_in(clk), .scl_line_in(scl_line), .sda_line_in(sda_line),
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe)
  );

  // Compare and count
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Register write, both halves offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  // Register read
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // Send a byte and check the answer in the ack slot
  task automatic put(input logic [7:0] b, input logic exp_ack);
    mst.send(b, ack);
    cmp("ack", 32'(exp_ack), 32'(ack));
  endtask
  // Note a byte expected on the command or display path
  task automatic note(input logic ram, input logic [7:0] b);
    if (ram) begin
      exp_ram.push_back({ptr, b});
      ptr++;
    end else begin
      exp_cmd.push_back(b);
    end
  endtask

  // Consumers stall at random; each popped byte meets the oldest note
  always @(posedge clk) begin
    rnd = $random(seed);
    cmd_ready <= rnd[0] & ~stall;
    ram_ready <= rnd[1] & ~stall;
    if (scl_oe === 1'b1) str_seen <= 1'b1;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      cmp("cmd", exp_cmd.size() > 0 ? 32'(exp_cmd.pop_front()) : 32'hXXXXXXXX, 32'(cmd_byte));
    end
    if (ram_valid === 1'b1 && ram_ready === 1'b1) begin
      cmp("ram", exp_ram.size() > 0 ? 32'(exp_ram.pop_front()) : 32'hXXXXXXXX,
          32'({ram_addr, ram_byte}));
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    axi_rd(OFS_CTRL);
    cmp("ctrl", 32'(RST_ENABLE), rv);
    axi_rd(OFS_TXDATA);
    cmp("txdata", 32'(RST_TXDATA), rv);
    axi_rd(8'h10);
    cmp("rresp", 32'(RESP_SLVERR), 32'(rr));
    axi_wr(8'h14, 32'h1);
    cmp("bresp", 32'(RESP_SLVERR), 32'(rr));
    // Address match under both strap levels
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 2; b++) begin
        strap <= s[0];
        repeat (4) @(posedge clk);
        mst.start();
        put({ADDR_FIXED, b[0], 1'b0}, b == s);
        put(8'h40, b == s);
        mst.stop();
      end
    end
    // Every target field under a continuing control byte, pointer near wrap
    ptr = 7'h7E;
    axi_wr(OFS_PTR, 32'h7E);
    mst.start();
    put({ADDR_FIXED, 1'b1, 1'b0}, 1'b1);
    for (int t = 0; t < 4; t++) begin
      d = 8'($random(seed));
      put({1'b1, 2'(t), 5'h00}, 1'b1);
      note(t == 1, d);
      put(d, 1'b1);
    end
    // Last control byte to RAM; consumers hold for 2000 clocks, long enough for the buffer to refuse
    stall <= 1'b1;
    put(8'h20, 1'b1);
    fork
      begin
        repeat (2000) @(posedge clk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      note(1'b1, d);
      put(d, 1'b1);
    end
    mst.stop();
    cmp("stretch", 32'h1, 32'(str_seen));
    axi_rd(OFS_PTR);
    cmp("ptr", 32'(ptr), rv);
    // Idle, RAM target, last control, seventeen bytes received since reset
    axi_rd(OFS_STATUS);
    cmp("status", 32'h00001104, rv);
    // Bank select and pointer set commands, a cut byte, then RAM data
    mst.start();
    put({ADDR_FIXED, 1'b1, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = i ? 8'h80 : 8'h10;
      note(1'b0, d);
      put(d, 1'b1);
    end
    for (int i = 0; i < 4; i++) mst.bit_out(1'b1, ack);
    mst.start();
    put({ADDR_FIXED, 1'b1, 1'b0}, 1'b1);
    put(8'h20, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      note(1'b1, d);
      put(d, 1'b1);
    end
    mst.stop();
    // Read the loaded byte twice; no ack on the last, then SDA is free
    axi_wr(OFS_TXDATA, 32'h5A);
    mst.start();
    put({ADDR_FIXED, 1'b1, 1'b1}, 1'b1);
    for (int i = 1; i >= 0; i--) begin
      mst.recv(i[0], d);
      cmp("read", 32'h5A, 32'(d));
    end
    cmp("sda_free", 32'h0, 32'(sda_oe));
    mst.stop();
    // Disabled port ignores its address
    axi_wr(OFS_CTRL, 32'h0);
    mst.start();
    put({ADDR_FIXED, 1'b1, 1'b0}, 1'b0);
    mst.stop();
    axi_wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 500 && exp_cmd.size() + exp_ram.size() > 0; i++) @(posedge clk);
    cmp("left", 32'h0, 32'(exp_cmd.size() + exp_ram.size()));
    end_sim();
  end

  // Watchdog against a hung transfer
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
